// ==== logic/hbs_boot_sequencer.sv ====
// Behaviour
// - non-removable strap code selects none, port 2, ports 2-3 up to ports 2-6
// - charging strap code selects none, port 1, 1-2, 1-3, 1-4, ports 1-6
// - each gpio is input with optional pull or output driving low or high
// - gpio registers writable at runtime from smbus slave or hub feature path
// - reset input high means standby: pins released, nothing else runs
// - reset input low runs the boot stages toward hub operation
// - entering standby aborts everything and returns all registers except the configuration memory to defaults
// - reset release enters the spi init stage with defaults initialised
// - probe reads four signature bytes at 0xfffa; match means external execution
// - spi probe supports single or dual data and mode 0 or mode 3
// - without spi strap the probe is skipped and default load follows
// - default load writes rom defaults, then overrides from sampled straps
// - slave mode strap plus both smbus pins high goes to soc setup
// - soc setup waits forever, never advancing on its own
// - soc writes during setup may modify any default setting
// - mode strap: 200k pull-up slave setup, 200k pull-down bridge master
// - all strap levels latched right after reset release
// - after configuration idle until bus power, then charger detect or connect
`timescale 1ns/1ps
`include "hbs_map.svh"

module hbs_boot_sequencer import hbs_pkg::*; (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic spi_mode_strap,
    input wire logic spi_dual_sel,
    input wire logic spi_mode3_sel,
    input wire logic [2:0] nonremovable_select_strap,
    input wire logic [2:0] charge_port_select_strap,
    input wire logic [2:0] iface_mode_strap,
    input wire logic smbus_data_pin,
    input wire logic smbus_clock_pin,
    input wire logic vbus_present,
    input wire logic smb_wr_valid,
    input wire logic [7:0] smb_wr_addr,
    input wire logic [7:0] smb_wr_data,
    input wire logic [7:0] smb_rd_addr,
    input wire logic hfc_wr_valid,
    input wire logic [7:0] hfc_wr_addr,
    input wire logic [7:0] hfc_wr_data,
    input wire logic spi_io0_i,
    input wire logic spi_io1_i,
    output logic standby_r,
    output hbs_stage_t stage_r,
    output logic ext_boot_r,
    output logic [5:0] nonremovable_ports_r,
    output logic [5:0] charge_ports_r,
    output logic slave_setup_r,
    output logic bridge_master_r,
    output logic [7:0] smb_rd_data_r,
    output logic spi_cs_n_r,
    output logic spi_sck_r,
    output logic spi_ctl_oe_n_r,
    output logic spi_io0_o_r,
    output logic spi_io0_oe_n_r,
    output logic [7:0] gpio_o_r,
    output logic [7:0] gpio_oe_n_r,
    output logic [7:0] gpio_pu_en_r,
    output logic [7:0] gpio_pd_en_r
);

    ////////////////////////////////////////////////////////////////////////////
    // decode functions

    function automatic logic [5:0] nonrem_mask(input hbs_code_t code);
        unique case (code)
            `HBS_CODE_L0: nonrem_mask = 6'h00;
            `HBS_CODE_L1: nonrem_mask = 6'h02;
            `HBS_CODE_L2: nonrem_mask = 6'h06;
            `HBS_CODE_L3: nonrem_mask = 6'h0e;
            `HBS_CODE_L4: nonrem_mask = 6'h1e;
            `HBS_CODE_L5: nonrem_mask = 6'h3e;
            default: nonrem_mask = `HBS_PORTS_NONE;
        endcase
    endfunction

    function automatic logic [5:0] charge_mask(input hbs_code_t code);
        unique case (code)
            `HBS_CODE_L0: charge_mask = 6'h00;
            `HBS_CODE_L1: charge_mask = 6'h01;
            `HBS_CODE_L2: charge_mask = 6'h03;
            `HBS_CODE_L3: charge_mask = 6'h07;
            `HBS_CODE_L4: charge_mask = 6'h0f;
            `HBS_CODE_L5: charge_mask = 6'h3f;
            default: charge_mask = `HBS_PORTS_NONE;
        endcase
    endfunction

    function automatic logic [7:0] rom_default(input logic [7:0] addr);
        rom_default = (addr == `HBS_DEF_CTRL_ADDR) ? `HBS_DEF_CTRL_VAL : `HBS_DEF_FILL;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // strap latch

    hbs_code_t nonrem_code_r;
    hbs_code_t charge_code_r;
    hbs_code_t mode_code_r;
    logic spi_strap_r;
    logic dual_r;
    logic mode3_r;
    logic straps_valid_r;

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            nonrem_code_r <= `HBS_CODE_L0;
            charge_code_r <= `HBS_CODE_L0;
            mode_code_r <= `HBS_CODE_L0;
            spi_strap_r <= 1'b0;
            dual_r <= 1'b0;
            mode3_r <= 1'b0;
            straps_valid_r <= 1'b0;
        end else if (!straps_valid_r) begin
            nonrem_code_r <= nonremovable_select_strap;
            charge_code_r <= charge_port_select_strap;
            mode_code_r <= iface_mode_strap;
            spi_strap_r <= spi_mode_strap;
            dual_r <= spi_dual_sel;
            mode3_r <= spi_mode3_sel;
            straps_valid_r <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // spi rom probe engine

    logic [1:0] spi_div_r;
    logic spi_tick;
    logic spi_act_r;
    logic spi_ph_r;
    logic spi_fin_r;
    logic spi_done_r;
    logic [6:0] spi_cnt_r;
    logic [31:0] spi_out_r;
    logic [31:0] spi_in_r;
    logic [6:0] in_start;
    logic [6:0] rises_total;

    assign spi_tick = (spi_div_r == `HBS_SPI_DIV_LAST);
    // dual adds eight dummy clocks and halves the data clocks
    assign in_start = dual_r ? `HBS_DUAL_IN_START : `HBS_SINGLE_IN_START;
    assign rises_total = dual_r ? `HBS_DUAL_RISES : `HBS_SINGLE_RISES;

    // the rom is slow-clocked on purpose: the probe is short, margin matters more
    always_ff @(posedge sys_clk) begin
        if (sys_rst || !spi_act_r) begin
            spi_div_r <= 2'h0;
        end else begin
            spi_div_r <= spi_div_r + 2'h1;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            spi_act_r <= 1'b0;
            spi_ph_r <= 1'b0;
            spi_fin_r <= 1'b0;
            spi_done_r <= 1'b0;
            spi_cnt_r <= `HBS_SPI_CNT_ZERO;
            spi_out_r <= 32'h0;
            spi_in_r <= 32'h0;
        end else begin
            spi_done_r <= 1'b0;
            if (stage_r == ST_SPI_PROBE && !spi_act_r && !spi_fin_r) begin
                spi_act_r <= 1'b1;
                spi_ph_r <= 1'b0;
                spi_cnt_r <= `HBS_SPI_CNT_ZERO;
                spi_out_r <= {(dual_r ? `HBS_CMD_DREAD : `HBS_CMD_READ), `HBS_SIG_ADDR};
            end else if (spi_act_r && spi_tick) begin
                if (!spi_ph_r) begin
                    spi_ph_r <= 1'b1;
                    spi_cnt_r <= spi_cnt_r + `HBS_SPI_CNT_ONE;
                end else begin
                    // sample late in the high phase, one system clock before the rom shifts
                    spi_ph_r <= 1'b0;
                    if (spi_cnt_r > in_start) begin
                        spi_in_r <= dual_r ? {spi_in_r[29:0], spi_io1_i, spi_io0_i}
                                           : {spi_in_r[30:0], spi_io1_i};
                    end
                    if (spi_cnt_r == rises_total) begin
                        spi_act_r <= 1'b0;
                        spi_fin_r <= 1'b1;
                        spi_done_r <= 1'b1;
                    end else begin
                        spi_out_r <= {spi_out_r[30:0], 1'b0};
                    end
                end
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            spi_cs_n_r <= 1'b1;
            spi_sck_r <= 1'b0;
            spi_ctl_oe_n_r <= 1'b1;
            spi_io0_o_r <= 1'b0;
            spi_io0_oe_n_r <= 1'b1;
        end else begin
            spi_cs_n_r <= !spi_act_r;
            // idle level follows mode 0 or mode 3
            spi_sck_r <= spi_act_r ? spi_ph_r : mode3_r;
            spi_ctl_oe_n_r <= 1'b0;
            spi_io0_o_r <= spi_out_r[31];
            spi_io0_oe_n_r <= !(spi_act_r && !(dual_r && spi_cnt_r > `HBS_SINGLE_IN_START));
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // boot stage sequencer

    logic [7:0] load_addr_r;
    hbs_ovr_t ovr_r;

    // stages advance only while out of reset
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            // release lands in the spi init stage
            stage_r <= ST_SPI_INIT;
            ext_boot_r <= 1'b0;
            load_addr_r <= 8'h00;
            ovr_r <= OVR_NONREM;
        end else begin
            unique case (stage_r)
                ST_SPI_INIT: begin
                    if (straps_valid_r) begin
                        stage_r <= spi_strap_r ? ST_SPI_PROBE : ST_CFG_RD;
                    end
                end
                ST_SPI_PROBE: begin
                    if (spi_done_r) begin
                        ext_boot_r <= (spi_in_r == `HBS_SIG_WORD);
                        stage_r <= ST_CFG_RD;
                    end
                end
                ST_CFG_RD: begin
                    load_addr_r <= load_addr_r + 8'h01;
                    if (load_addr_r == `HBS_LAST_ADDR) begin
                        stage_r <= ST_CFG_OVR;
                    end
                end
                ST_CFG_OVR: begin
                    unique case (ovr_r)
                        OVR_NONREM: ovr_r <= OVR_BC;
                        OVR_BC: ovr_r <= OVR_MODE;
                        OVR_MODE: stage_r <= ST_STRAP;
                        default: stage_r <= ST_STRAP;
                    endcase
                end
                ST_STRAP: begin
                    // slave detect on both smbus pins
                    if (mode_code_r == `HBS_CODE_SLAVE && smbus_data_pin && smbus_clock_pin) begin
                        stage_r <= ST_SOC_CFG;
                    end else begin
                        stage_r <= ST_OTP_CFG;
                    end
                end
                ST_SOC_CFG: begin
                    // no timeout; done register ends setup
                    if (smb_wr_valid && smb_wr_addr == `HBS_DONE_ADDR) begin
                        stage_r <= ST_OTP_CFG;
                    end
                end
                ST_OTP_CFG: stage_r <= ST_IDLE;
                ST_IDLE: begin
                    if (vbus_present) begin
                        stage_r <= (charge_ports_r != `HBS_PORTS_NONE) ? ST_CHGDET : ST_CONNECT;
                    end
                end
                ST_CHGDET: stage_r <= ST_CONNECT;
                ST_CONNECT: begin
                    if (!vbus_present) begin
                        stage_r <= ST_IDLE;
                    end
                end
                default: stage_r <= ST_SPI_INIT;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // configuration memory and strap overrides

    logic mem_we;
    logic [7:0] mem_wa;
    logic [7:0] mem_wd;
    logic [7:0] mem_q;
    logic [7:0] rd_addr_d_r;

    always_comb begin
        mem_we = 1'b0;
        mem_wa = load_addr_r;
        mem_wd = rom_default(load_addr_r);
        if (stage_r == ST_CFG_RD) begin
            mem_we = 1'b1;
        end else if (stage_r == ST_CFG_OVR) begin
            mem_we = 1'b1;
            unique case (ovr_r)
                OVR_NONREM: begin
                    mem_wa = `HBS_NONREM_ADDR;
                    mem_wd = {2'h0, nonrem_mask(nonrem_code_r)};
                end
                OVR_BC: begin
                    mem_wa = `HBS_BC_ADDR;
                    mem_wd = {2'h0, charge_mask(charge_code_r)};
                end
                default: begin
                    mem_wa = `HBS_MODE_ADDR;
                    mem_wd = {5'h00, mode_code_r};
                end
            endcase
        end else if (stage_r == ST_SOC_CFG && smb_wr_valid) begin
            mem_we = 1'b1;
            mem_wa = smb_wr_addr;
            mem_wd = smb_wr_data;
        end
    end

    hbs_cfg_mem u_mem (
        .sys_clk(sys_clk),
        .wr_en(mem_we),
        .wr_addr(mem_wa),
        .wr_data(mem_wd),
        .rd_addr(smb_rd_addr),
        .rd_data_r(mem_q)
    );

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            nonremovable_ports_r <= `HBS_PORTS_NONE;
            charge_ports_r <= `HBS_PORTS_NONE;
            slave_setup_r <= 1'b0;
            bridge_master_r <= 1'b0;
        end else if (stage_r == ST_CFG_OVR) begin
            nonremovable_ports_r <= nonrem_mask(nonrem_code_r);
            charge_ports_r <= charge_mask(charge_code_r);
            slave_setup_r <= (mode_code_r == `HBS_CODE_SLAVE);
            bridge_master_r <= (mode_code_r == `HBS_CODE_BRIDGE);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // gpio control

    logic [7:0] gpio_dir_r;
    logic [7:0] gpio_out_r;
    logic [7:0] gpio_pu_r;
    logic [7:0] gpio_pd_r;
    logic gw_valid;
    logic [7:0] gw_addr;
    logic [7:0] gw_data;

    // smbus wins a same-cycle collision with the feature path
    assign gw_valid = smb_wr_valid || hfc_wr_valid;
    assign gw_addr = smb_wr_valid ? smb_wr_addr : hfc_wr_addr;
    assign gw_data = smb_wr_valid ? smb_wr_data : hfc_wr_data;

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            gpio_dir_r <= `HBS_GPIO_RST;
            gpio_out_r <= `HBS_GPIO_RST;
            gpio_pu_r <= `HBS_GPIO_RST;
            gpio_pd_r <= `HBS_GPIO_RST;
        end else if (gw_valid) begin
            if (gw_addr == `HBS_GPIO_DIR_ADDR) gpio_dir_r <= gw_data;
            if (gw_addr == `HBS_GPIO_OUT_ADDR) gpio_out_r <= gw_data;
            if (gw_addr == `HBS_GPIO_PU_ADDR) gpio_pu_r <= gw_data;
            if (gw_addr == `HBS_GPIO_PD_ADDR) gpio_pd_r <= gw_data;
        end
    end

    // pulls only on inputs; pull-up wins if both are set
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            standby_r <= 1'b1;
            gpio_o_r <= 8'h00;
            gpio_oe_n_r <= 8'hff;
            gpio_pu_en_r <= 8'h00;
            gpio_pd_en_r <= 8'h00;
        end else begin
            standby_r <= 1'b0;
            gpio_o_r <= gpio_out_r;
            gpio_oe_n_r <= ~gpio_dir_r;
            gpio_pu_en_r <= ~gpio_dir_r & gpio_pu_r;
            gpio_pd_en_r <= ~gpio_dir_r & gpio_pd_r & ~gpio_pu_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // smbus read path

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            rd_addr_d_r <= 8'h00;
            smb_rd_data_r <= 8'h00;
        end else begin
            rd_addr_d_r <= smb_rd_addr;
            unique case (rd_addr_d_r)
                `HBS_STAGE_ADDR: smb_rd_data_r <= {3'h0, ext_boot_r, stage_r};
                `HBS_GPIO_DIR_ADDR: smb_rd_data_r <= gpio_dir_r;
                `HBS_GPIO_OUT_ADDR: smb_rd_data_r <= gpio_out_r;
                `HBS_GPIO_PU_ADDR: smb_rd_data_r <= gpio_pu_r;
                `HBS_GPIO_PD_ADDR: smb_rd_data_r <= gpio_pd_r;
                default: smb_rd_data_r <= mem_q;
            endcase
        end
    end

endmodule // hbs_boot_sequencer

// ==== shared/hbs_map.svh ====
`ifndef HBS_MAP_SVH
`define HBS_MAP_SVH

// spi rom probe
`define HBS_CMD_READ 8'h03
`define HBS_CMD_DREAD 8'h3b
`define HBS_SIG_ADDR 24'hfffa
`define HBS_EXEC_ADDR 24'h000000
// ascii "2DFU"
`define HBS_SIG_WORD 32'h32444655
`define HBS_SPI_DIV_LAST 2'h3
`define HBS_SINGLE_IN_START 7'h20
`define HBS_SINGLE_RISES 7'h40
`define HBS_DUAL_IN_START 7'h28
`define HBS_DUAL_RISES 7'h38
`define HBS_SPI_CNT_ZERO 7'h00
`define HBS_SPI_CNT_ONE 7'h01

// configuration space
`define HBS_LAST_ADDR 8'hff
`define HBS_DONE_ADDR 8'hff
`define HBS_STAGE_ADDR 8'hfe
`define HBS_NONREM_ADDR 8'h10
`define HBS_BC_ADDR 8'h11
`define HBS_MODE_ADDR 8'h12
`define HBS_DEF_CTRL_ADDR 8'h00
`define HBS_DEF_CTRL_VAL 8'h01
`define HBS_DEF_FILL 8'h00
`define HBS_GPIO_DIR_ADDR 8'h80
`define HBS_GPIO_OUT_ADDR 8'h81
`define HBS_GPIO_PU_ADDR 8'h82
`define HBS_GPIO_PD_ADDR 8'h83
`define HBS_GPIO_RST 8'h00

// six-level strap codes, weakest pull-down first
`define HBS_CODE_L0 3'h0
`define HBS_CODE_L1 3'h1
`define HBS_CODE_L2 3'h2
`define HBS_CODE_L3 3'h3
`define HBS_CODE_L4 3'h4
`define HBS_CODE_L5 3'h5
`define HBS_CODE_BRIDGE 3'h0
`define HBS_CODE_SLAVE 3'h1
`define HBS_PORTS_NONE 6'h00

`endif

// ==== shared/hbs_pkg.sv ====
package hbs_pkg;

    typedef enum logic [3:0] {
        ST_SPI_INIT,
        ST_SPI_PROBE,
        ST_CFG_RD,
        ST_CFG_OVR,
        ST_STRAP,
        ST_SOC_CFG,
        ST_OTP_CFG,
        ST_IDLE,
        ST_CHGDET,
        ST_CONNECT
    } hbs_stage_t;

    typedef logic [2:0] hbs_code_t;

    typedef enum logic [1:0] {
        OVR_NONREM,
        OVR_BC,
        OVR_MODE
    } hbs_ovr_t;

endpackage

// ==== logic/hbs_cfg_mem.sv ====
`timescale 1ns/1ps

module hbs_cfg_mem (
    input wire logic sys_clk,
    input wire logic wr_en,
    input wire logic [7:0] wr_addr,
    input wire logic [7:0] wr_data,
    input wire logic [7:0] rd_addr,
    output logic [7:0] rd_data_r
);

    logic [7:0] mem [0:255];

    always_ff @(posedge sys_clk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
    end

    // read data registered; written byte visible one cycle after the write
    always_ff @(posedge sys_clk) begin
        rd_data_r <= mem[rd_addr];
    end

endmodule // hbs_cfg_mem

// ==== bench/hbs_boot_sequencer_chk.sv ====
`timescale 1ns/1ps

module hbs_boot_sequencer_chk import hbs_pkg::*; (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic smbus_data_pin,
    input wire logic smbus_clock_pin,
    input wire logic vbus_present,
    input wire logic smb_wr_valid,
    input wire logic [7:0] smb_wr_addr,
    input wire logic standby_r,
    input wire hbs_stage_t stage_r,
    input wire logic [5:0] charge_ports_r,
    input wire logic slave_setup_r,
    input wire logic bridge_master_r,
    input wire logic spi_cs_n_r,
    input wire logic [7:0] gpio_oe_n_r
);
    logic done_wr;
    assign done_wr = smb_wr_valid && smb_wr_addr == 8'hff;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (sys_rst);

    ////////////////////////////////////////////////////////////
    stby_release_a: assert property (
        $fell(sys_rst) |-> standby_r && spi_cs_n_r && gpio_oe_n_r == 8'hff
            && stage_r == ST_SPI_INIT) else $error("outputs not reset in standby");
    hub_wake_a: assert property (
        $fell(sys_rst) |=> !standby_r) else $error("standby flag stuck after release");
    init_leave_a: assert property (
        $fell(sys_rst) |-> stage_r == ST_SPI_INIT ##1 stage_r == ST_SPI_INIT
            ##1 stage_r != ST_SPI_INIT) else $error("init stage length wrong");
    probe_select_a: assert property (
        !spi_cs_n_r |-> stage_r == ST_SPI_PROBE) else $error("rom selected outside probe");
    strap_route_a: assert property (
        stage_r == ST_STRAP |=> stage_r == ((slave_setup_r && smbus_data_pin
            && smbus_clock_pin) ? ST_SOC_CFG : ST_OTP_CFG)) else $error("strap route wrong");
    soc_wait_a: assert property (
        stage_r == ST_SOC_CFG && !done_wr |=> stage_r == ST_SOC_CFG)
        else $error("soc setup left on its own");
    soc_done_a: assert property (
        stage_r == ST_SOC_CFG && done_wr |=> stage_r == ST_OTP_CFG ##1 stage_r == ST_IDLE)
        else $error("done write did not end setup");
    vbus_route_a: assert property (
        stage_r == ST_IDLE && vbus_present |=> stage_r == ((charge_ports_r != 6'h00)
            ? ST_CHGDET : ST_CONNECT)) else $error("bus power route wrong");
    mode_excl_a: assert property (
        stage_r == ST_STRAP |-> !(slave_setup_r && bridge_master_r))
        else $error("both interface modes set");

    cover property (stage_r == ST_SOC_CFG);
    cover property (stage_r == ST_CHGDET);
    cover property (!spi_cs_n_r);
endmodule // hbs_boot_sequencer_chk

bind hbs_boot_sequencer hbs_boot_sequencer_chk u_chk (.sys_clk, .sys_rst, .smbus_data_pin,
    .smbus_clock_pin, .vbus_present, .smb_wr_valid, .smb_wr_addr, .standby_r, .stage_r,
    .charge_ports_r, .slave_setup_r, .bridge_master_r, .spi_cs_n_r, .gpio_oe_n_r);

// ==== bench/hbs_rom_model.sv ====
`timescale 1ns/1ps

module hbs_rom_model (
    input wire logic cs_n,
    input wire logic sck,
    input wire logic mosi,
    input wire logic [31:0] sig_word,
    output logic io0,
    output logic io1,
    output logic [31:0] cmd_addr
);
    // capacity and speed: only the signature bytes are stored, answers are instant
    localparam int ROM_KBIT = 1024;
    int cnt;
    initial {io1, io0, cnt} = 0;

    always @(negedge cs_n) cnt = 0;
    always @(posedge sck) if (!cs_n) begin
        if (cnt < 32) cmd_addr = {cmd_addr[30:0], mosi};
        cnt = cnt + 1;
    end

    ////////////////////////////////////////////////////////////
    // data changes after each fall; an undriven line toggles so stale bits never match
    always @(negedge sck or posedge cs_n) begin
        if (!cs_n && cmd_addr[31:24] == 8'h3b && cnt >= 40 && cnt < 56)
            {io1, io0} = sig_word[31 - 2 * (cnt - 40) -: 2];
        else if (!cs_n && cmd_addr[31:24] == 8'h03 && cnt >= 32 && cnt < 64)
            io1 = sig_word[63 - cnt];
        else
            {io1, io0} = ~{io1, io0};
    end
endmodule // hbs_rom_model

// ==== bench/testbench.sv ====
`timescale 1ns/1ps

module testbench import hbs_pkg::*; ;
    logic sys_clk, sys_rst, spi_mode_strap, spi_dual_sel, spi_mode3_sel, vbus_present;
    logic [2:0] nonremovable_select_strap, charge_port_select_strap, iface_mode_strap;
    logic smbus_data_pin, smbus_clock_pin, smb_wr_valid, hfc_wr_valid;
    logic [7:0] smb_wr_addr, smb_wr_data, smb_rd_addr, hfc_wr_addr, hfc_wr_data;
    logic spi_io0_i, spi_io1_i, rom_io0, cs_wire, sck_wire;
    logic standby_r, ext_boot_r, slave_setup_r, bridge_master_r, spi_cs_n_r, spi_sck_r;
    logic spi_ctl_oe_n_r, spi_io0_o_r, spi_io0_oe_n_r;
    hbs_stage_t stage_r;
    logic [5:0] nonremovable_ports_r, charge_ports_r;
    logic [7:0] smb_rd_data_r, gpio_o_r, gpio_oe_n_r, gpio_pu_en_r, gpio_pd_en_r;
    logic [31:0] rom_sig, rom_cmd;
    int err_total, total_checks;

    // shared data line: whoever has it enabled sets the level both sides see
    assign spi_io0_i = spi_io0_oe_n_r ? rom_io0 : spi_io0_o_r;
    assign cs_wire = spi_cs_n_r | spi_ctl_oe_n_r;
    assign sck_wire = spi_sck_r & ~spi_ctl_oe_n_r;

    hbs_boot_sequencer u_hbs_boot_sequencer (.*);
    hbs_rom_model u_hbs_rom_model (.cs_n(cs_wire), .sck(sck_wire), .mosi(spi_io0_i),
        .sig_word(rom_sig), .io0(rom_io0), .io1(spi_io1_i), .cmd_addr(rom_cmd));

    initial begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end

    ////////////////////////////////////////////////////////////
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic results();
        $display("checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask

    task automatic wait_stage(input hbs_stage_t st, input int bound);
        int n;
        n = 0;
        while (stage_r !== st && n < bound) begin
            @(negedge sys_clk);
            n++;
        end
        if (stage_r !== st) begin
            err_total++;
            $display("CHECK FAILED stage wait expected %h seen %h", st, stage_r);
            results();
        end
    endtask

    task automatic boot(input logic [2:0] spi, input logic [2:0] code, input logic [2:0] im,
        input logic [1:0] pins);
        @(negedge sys_clk);
        sys_rst = 1'b1;
        {spi_mode_strap, spi_dual_sel, spi_mode3_sel} = spi;
        nonremovable_select_strap = code;
        charge_port_select_strap = 3'h5 - code;
        iface_mode_strap = im;
        {smbus_data_pin, smbus_clock_pin} = pins;
        repeat (2) @(negedge sys_clk);
        sys_rst = 1'b0;
        repeat (3) @(negedge sys_clk);
        // strap changes after the latch must not matter
        {spi_mode_strap, spi_dual_sel, spi_mode3_sel} = ~spi;
        nonremovable_select_strap = 3'h5 - code;
        charge_port_select_strap = code;
        iface_mode_strap = im ^ 3'h1;
    endtask

    task automatic wr(input logic hfc, input logic [7:0] a, input logic [7:0] d);
        @(negedge sys_clk);
        smb_wr_valid = !hfc;
        hfc_wr_valid = hfc;
        {smb_wr_addr, smb_wr_data, hfc_wr_addr, hfc_wr_data} = {a, d, a, d};
        @(negedge sys_clk);
        {smb_wr_valid, hfc_wr_valid} = 2'b00;
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(negedge sys_clk);
        smb_rd_addr = a;
        repeat (3) @(negedge sys_clk);
        chk("read data", exp, smb_rd_data_r);
    endtask

    task automatic chk_standby();
        chk("standby", 32'h1, standby_r);
        chk("stage", ST_SPI_INIT, stage_r);
        chk("gpio enables", 32'hff, gpio_oe_n_r);
        chk("gpio pulls", 32'h0, {gpio_pu_en_r, gpio_pd_en_r, gpio_o_r});
        chk("spi enables", 32'h7, {spi_ctl_oe_n_r, spi_io0_oe_n_r, spi_cs_n_r});
    endtask

    ////////////////////////////////////////////////////////////
    task automatic s_probe_single();
        rom_sig = "2DFT";
        boot(3'b100, 3'h5, 3'h0, 2'b00);
        wait_stage(ST_CFG_RD, 1200);
        chk("single command", {8'h03, 24'h00fffa}, rom_cmd);
        chk("signature flag", 32'h0, ext_boot_r);
        wait_stage(ST_IDLE, 600);
        chk("nonremovable", 32'h3e, nonremovable_ports_r);
        chk("charging", 32'h0, charge_ports_r);
        chk("mode", 32'h1, {slave_setup_r, bridge_master_r});
    endtask

    task automatic s_probe_dual();
        rom_sig = "2DFU";
        boot(3'b111, 3'h0, 3'h0, 2'b00);
        wait_stage(ST_CFG_RD, 1200);
        chk("dual command", {8'h3b, 24'h00fffa}, rom_cmd);
        chk("signature flag", 32'h1, ext_boot_r);
        chk("mode 3 idle clock", 32'h1, spi_sck_r);
    endtask

    task automatic s_decode();
        logic [5:0] nr_tab [6] = '{6'h00, 6'h02, 6'h06, 6'h0e, 6'h1e, 6'h3e};
        logic [5:0] bc_tab [6] = '{6'h00, 6'h01, 6'h03, 6'h07, 6'h0f, 6'h3f};
        for (int k = 0; k < 6; k++) begin
            // slave strap with one pin only must not reach soc setup
            boot(3'b000, k[2:0], k[2:0], 2'b10);
            wait_stage(ST_IDLE, 600);
            chk("nonremovable", nr_tab[k], nonremovable_ports_r);
            chk("charging", bc_tab[5 - k], charge_ports_r);
            chk("mode", {(k == 1), (k == 0)}, {slave_setup_r, bridge_master_r});
            chk("probe skipped", 32'h0, ext_boot_r);
            vbus_present = 1'b1;
            @(negedge sys_clk);
            chk("bus power", (k == 5) ? ST_CONNECT : ST_CHGDET, stage_r);
            vbus_present = 1'b0;
        end
    endtask

    task automatic s_soc();
        boot(3'b000, 3'h2, 3'h1, 2'b11);
        wait_stage(ST_SOC_CFG, 600);
        wr(1'b0, 8'h20, 8'h5a);
        rd(8'h20, 8'h5a);
        repeat (300) @(negedge sys_clk);
        chk("soc wait", ST_SOC_CFG, stage_r);
        wr(1'b0, 8'hff, 8'h00);
        chk("done write", ST_OTP_CFG, stage_r);
        @(negedge sys_clk);
        chk("after done", ST_IDLE, stage_r);
        wr(1'b0, 8'h20, 8'ha5);
        rd(8'h20, 8'h5a);
    endtask

    task automatic s_gpio();
        wr(1'b0, 8'h80, 8'h0f);
        wr(1'b1, 8'h81, 8'h05);
        wr(1'b1, 8'h82, 8'h30);
        wr(1'b0, 8'h83, 8'hc0);
        repeat (3) @(negedge sys_clk);
        chk("gpio direction", 32'hf0, gpio_oe_n_r);
        chk("gpio levels", 32'h05, gpio_o_r);
        chk("gpio pulls", 32'h30c0, {gpio_pu_en_r, gpio_pd_en_r});
    endtask

    task automatic s_midreset();
        @(negedge sys_clk);
        sys_rst = 1'b1;
        @(negedge sys_clk);
        chk_standby();
        sys_rst = 1'b0;
        wait_stage(ST_IDLE, 1000);
        chk("gpio after reset", 32'hff, gpio_oe_n_r);
    endtask

    initial begin
        sys_rst = 1'b1;
        {spi_mode_strap, spi_dual_sel, spi_mode3_sel, vbus_present} = 4'h0;
        {smbus_data_pin, smbus_clock_pin, smb_wr_valid, hfc_wr_valid} = 4'h0;
        {nonremovable_select_strap, charge_port_select_strap, iface_mode_strap} = 9'h000;
        {smb_wr_addr, smb_wr_data, smb_rd_addr, hfc_wr_addr, hfc_wr_data} = 40'h0;
        rom_sig = 32'h0;
        err_total = 0;
        total_checks = 0;
        repeat (16) @(negedge sys_clk);
        chk_standby();
        s_probe_single();
        s_probe_dual();
        s_decode();
        s_soc();
        s_gpio();
        s_midreset();
        results();
    end
endmodule // testbench
